// File: shared/brc_pkg.sv
package brc_pkg;

   // Reference clock of the sequencer
   localparam int unsigned CLK_PERIOD_NS   = 100;

   // Supervisor release delay after supply good and manual input high
   localparam int unsigned SUP_DELAY_NS    = 1000;
   localparam int unsigned SUP_DELAY_CYC   = (SUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SUP_CNT_W       = $clog2(SUP_DELAY_CYC + 1);

   // Clock manager figures
   localparam int unsigned INPUT_PERIOD_NS = 10;
   localparam int unsigned DIVIDE_RATIO    = 2;
   localparam int unsigned PHASE_STEPS     = 4;
   localparam int unsigned PHASE_CNT_W     = $clog2(PHASE_STEPS * DIVIDE_RATIO);
   localparam int unsigned LOCK_CYC        = 16;
   localparam int unsigned LOCK_CNT_W      = $clog2(LOCK_CYC + 1);

   // Ticks of the system clock between bus release and core release
   localparam int unsigned CORE_GAP_TICKS  = 4;
   localparam int unsigned GAP_CNT_W       = $clog2(CORE_GAP_TICKS + 1);

   // External reset polarity of the processor reset controller
   localparam logic        EXT_RESET_HIGH  = 1'b0;

   // Register offsets
   localparam logic [11:0] CTRL_OFFS       = 12'h000;
   localparam logic [11:0] STAT_OFFS       = 12'h004;
   localparam logic [11:0] CNT_OFFS        = 12'h008;

   // Control fields and reset value
   localparam int unsigned CTRL_DBG_BIT    = 0;
   localparam int unsigned CTRL_HOLD_BIT   = 1;
   localparam logic [1:0]  CTRL_RST        = 2'h0;

   // Status fields
   localparam int unsigned ST_SUPPLY_BIT   = 0;
   localparam int unsigned ST_LOCAL_BIT    = 1;
   localparam int unsigned ST_BOARD_BIT    = 2;
   localparam int unsigned ST_SUPV_BIT     = 3;
   localparam int unsigned ST_LOCK_BIT     = 4;
   localparam int unsigned ST_BUS_BIT      = 5;
   localparam int unsigned ST_CORE_BIT     = 6;
   localparam int unsigned ST_STATE_LSB    = 8;

   // Board reset event counter
   localparam int unsigned EVT_CNT_W       = 16;

   // Processor reset sequencer states
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_BUS  = 3'b010,
      ST_RUN  = 3'b100
   } brc_state_t;

endpackage : brc_pkg

// File: src/brc_clk_mgr.sv
`timescale 1ns/1ns
module brc_clk_mgr #(
   parameter int unsigned LOCK_COUNT = brc_pkg::LOCK_CYC
) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Feedback of the in-phase clock
   input  wire logic feedback_clock_i,
   // Generated clocks and lock
   output logic      clk_phase_zero_o,
   output logic      clk_phase_quarter_o,
   output logic      divided_clock_o,
   output logic      lock_status_net_o,
   output logic      sys_tick_o
);

   logic [brc_pkg::PHASE_CNT_W-1:0] ph_q;
   logic [brc_pkg::LOCK_CNT_W-1:0]  lock_cnt_q;

   // Phase counter spans one divided clock period
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ph_q <= '0;
      end else begin
         ph_q <= ph_q + 1'b1;
      end
   end

   // Clock outputs decoded from the phase; quarter lags zero by one step
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_phase_zero_o    <= 1'b0;
         clk_phase_quarter_o <= 1'b0;
         divided_clock_o     <= 1'b0;
         sys_tick_o          <= 1'b0;
      end else begin
         clk_phase_zero_o    <= ~ph_q[1];
         clk_phase_quarter_o <= ph_q[1] ^ ph_q[0];
         divided_clock_o     <= ~ph_q[2];
         sys_tick_o          <= (ph_q == '0);
      end
   end

   // Lock once feedback has tracked the in-phase clock long enough
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_cnt_q        <= '0;
         lock_status_net_o <= 1'b0;
      end else if (feedback_clock_i != clk_phase_zero_o) begin
         lock_cnt_q        <= '0;
         lock_status_net_o <= 1'b0;
      end else if (lock_cnt_q == brc_pkg::LOCK_CNT_W'(LOCK_COUNT)) begin
         lock_status_net_o <= 1'b1;
      end else begin
         lock_cnt_q        <= lock_cnt_q + 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_zero_period;
      $rose(clk_phase_zero_o) |-> ##4 $rose(clk_phase_zero_o);
   endproperty
   a_zero_period : assert property (p_zero_period) else $error("in-phase period wrong");

   property p_quarter;
      $rose(clk_phase_zero_o) |=> $rose(clk_phase_quarter_o);
   endproperty
   a_quarter : assert property (p_quarter) else $error("quarter clock not one step late");

   property p_divided;
      $rose(divided_clock_o) |-> $rose(clk_phase_zero_o) ##8 $rose(divided_clock_o);
   endproperty
   a_divided : assert property (p_divided) else $error("divided clock period wrong");

   property p_unlock;
      (feedback_clock_i != clk_phase_zero_o) |=> !lock_status_net_o;
   endproperty
   a_unlock : assert property (p_unlock) else $error("lock kept on feedback mismatch");

endmodule : brc_clk_mgr

// File: src/brc_top.sv
`timescale 1ns/1ns
module brc_top #(
   parameter int unsigned LOCK_COUNT = brc_pkg::LOCK_CYC,
   parameter int unsigned GAP_TICKS  = brc_pkg::CORE_GAP_TICKS
) (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Board reset sources
   input  wire logic        supply_good_i,
   input  wire logic        config_done_i,
   input  wire logic        push_button_n_i,
   input  wire logic        interface_board_reset_n_i,
   input  wire logic        debug_system_reset_request_i,
   // Clock manager feedback
   input  wire logic        feedback_clock_i,
   // Board resets
   output logic             manual_reset_in_n_o,
   output logic             supervisor_reset_n_o,
   output logic             board_main_reset_n_o,
   output logic             board_reset_pwr_n_o,
   output logic             board_reset_dp_n_o,
   // Processor resets
   output logic             cpu_core_reset_o,
   output logic             bus_reset_o,
   // Generated clocks
   output logic             clk_phase_zero_o,
   output logic             clk_phase_quarter_o,
   output logic             divided_clock_o,
   output logic             lock_status_net_o
);

   localparam logic [brc_pkg::SUP_CNT_W-1:0] SUP_LAST =
      brc_pkg::SUP_CNT_W'(brc_pkg::SUP_DELAY_CYC - 1);
   localparam logic [brc_pkg::GAP_CNT_W-1:0] GAP_LAST =
      brc_pkg::GAP_CNT_W'(GAP_TICKS - 1);

   logic                             sys_tick;
   logic                             local_reset_n_d;
   logic                             sup_ok;
   logic [brc_pkg::SUP_CNT_W-1:0]    sup_cnt_q;
   logic                             hold_req;
   brc_pkg::brc_state_t              state_q;
   brc_pkg::brc_state_t              state_d;
   logic [brc_pkg::GAP_CNT_W-1:0]    gap_q;
   logic [brc_pkg::GAP_CNT_W-1:0]    gap_d;
   logic [1:0]                       ctrl_q;
   logic [brc_pkg::EVT_CNT_W-1:0]    evt_cnt_q;
   logic                             apb_access;
   logic                             apb_done;
   logic [31:0]                      rdata_d;
   logic                             hit_d;

   // Status word shared by the read mux and kept in one place
   function automatic logic [31:0] status_word(input brc_pkg::brc_state_t st);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[brc_pkg::ST_SUPPLY_BIT] = supply_good_i;
      w[brc_pkg::ST_LOCAL_BIT]  = manual_reset_in_n_o;
      w[brc_pkg::ST_BOARD_BIT]  = board_main_reset_n_o;
      w[brc_pkg::ST_SUPV_BIT]   = supervisor_reset_n_o;
      w[brc_pkg::ST_LOCK_BIT]   = lock_status_net_o;
      w[brc_pkg::ST_BUS_BIT]    = bus_reset_o;
      w[brc_pkg::ST_CORE_BIT]   = cpu_core_reset_o;
      w[brc_pkg::ST_STATE_LSB +: 3] = st;
      return w;
   endfunction : status_word

   // Clock manager; memory clocks and the system clock tick
   brc_clk_mgr #(
      .LOCK_COUNT (LOCK_COUNT)
   ) u_clk_mgr (
      .ref_clk_i           (ref_clk_i),
      .rst_i               (rst_i),
      .feedback_clock_i    (feedback_clock_i),
      .clk_phase_zero_o    (clk_phase_zero_o),
      .clk_phase_quarter_o (clk_phase_quarter_o),
      .divided_clock_o     (divided_clock_o),
      .lock_status_net_o   (lock_status_net_o),
      .sys_tick_o          (sys_tick)
   );

   // Local reset combines configuration done and the active-low button
   assign local_reset_n_d = config_done_i & push_button_n_i;

   // Manual input of the supervisor follows the local reset
   assign sup_ok = supply_good_i & manual_reset_in_n_o;

   // Local and board resets, one flop each so outputs are glitch free
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         manual_reset_in_n_o  <= 1'b0;
         board_main_reset_n_o <= 1'b0;
         board_reset_pwr_n_o  <= 1'b0;
         board_reset_dp_n_o   <= 1'b0;
      end else begin
         manual_reset_in_n_o  <= local_reset_n_d;
         // Same term to every device so they leave reset together
         board_main_reset_n_o <= local_reset_n_d & interface_board_reset_n_i;
         board_reset_pwr_n_o  <= local_reset_n_d & interface_board_reset_n_i;
         board_reset_dp_n_o   <= local_reset_n_d & interface_board_reset_n_i;
      end
   end

   // Supervisor: delay runs only while supply good and manual input high;
   // there is no watchdog input, so nothing else can pull the output
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sup_cnt_q            <= '0;
         supervisor_reset_n_o <= 1'b0;
      end else if (!sup_ok) begin
         sup_cnt_q            <= '0;
         supervisor_reset_n_o <= 1'b0;
      end else if (!supervisor_reset_n_o) begin
         if (sup_cnt_q == SUP_LAST) begin
            supervisor_reset_n_o <= 1'b1;
         end else begin
            sup_cnt_q <= sup_cnt_q + 1'b1;
         end
      end
   end

   // Every source that must keep the processor in reset
   assign hold_req = (board_main_reset_n_o == brc_pkg::EXT_RESET_HIGH)
                   | !lock_status_net_o
                   | !supervisor_reset_n_o
                   | debug_system_reset_request_i
                   | ctrl_q[brc_pkg::CTRL_DBG_BIT];

   // Reset sequencer: assertion is immediate, release waits for a
   // system clock edge so both resets leave on that clock
   always_comb begin
      state_d = state_q;
      gap_d   = gap_q;
      case (state_q)
         brc_pkg::ST_HOLD: begin
            if (sys_tick && !hold_req) begin
               state_d = brc_pkg::ST_BUS;
               gap_d   = '0;
            end
         end
         brc_pkg::ST_BUS: begin
            if (hold_req) begin
               state_d = brc_pkg::ST_HOLD;
            end else if (sys_tick && !ctrl_q[brc_pkg::CTRL_HOLD_BIT]) begin
               if (gap_q == GAP_LAST) begin
                  state_d = brc_pkg::ST_RUN;
               end else begin
                  gap_d = gap_q + 1'b1;
               end
            end
         end
         brc_pkg::ST_RUN: begin
            if (hold_req) begin
               state_d = brc_pkg::ST_HOLD;
            end else if (ctrl_q[brc_pkg::CTRL_HOLD_BIT]) begin
               state_d = brc_pkg::ST_BUS;
               gap_d   = '0;
            end
         end
         default: begin
            state_d = brc_pkg::ST_HOLD;
         end
      endcase
   end

   // Sequencer state and its registered reset outputs
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q          <= brc_pkg::ST_HOLD;
         gap_q            <= '0;
         cpu_core_reset_o <= 1'b1;
         bus_reset_o      <= 1'b1;
      end else begin
         state_q          <= state_d;
         gap_q            <= gap_d;
         cpu_core_reset_o <= (state_d != brc_pkg::ST_RUN);
         bus_reset_o      <= (state_d == brc_pkg::ST_HOLD);
      end
   end

   // Count falling edges of the board reset for software to inspect
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_cnt_q <= '0;
      end else if (board_main_reset_n_o && !(local_reset_n_d & interface_board_reset_n_i)) begin
         evt_cnt_q <= evt_cnt_q + 1'b1;
      end
   end

   // APB handshake: data and ready come one cycle into the access phase
   assign apb_access = psel_i & penable_i & ~pready_o;
   assign apb_done   = psel_i & penable_i & pready_o;

   // Address decode for reads and the error answer
   always_comb begin
      rdata_d = 32'h0000_0000;
      hit_d   = 1'b1;
      if (paddr_i == brc_pkg::CTRL_OFFS) begin
         rdata_d[1:0] = ctrl_q;
      end else if (paddr_i == brc_pkg::STAT_OFFS) begin
         rdata_d = status_word(state_q);
      end else if (paddr_i == brc_pkg::CNT_OFFS) begin
         rdata_d[brc_pkg::EVT_CNT_W-1:0] = evt_cnt_q;
      end else begin
         hit_d = 1'b0;
      end
   end

   // Answer registers; unmapped addresses answer with an error and zero
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= apb_access;
         pslverr_o <= apb_access & ~hit_d;
         if (apb_access && !pwrite_i) begin
            prdata_o <= rdata_d;
         end
      end
   end

   // Control register written on the completing edge; byte lane 0 only
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= brc_pkg::CTRL_RST;
      end else if (apb_done && pwrite_i && pstrb_i[0] && paddr_i == brc_pkg::CTRL_OFFS) begin
         ctrl_q <= pwdata_i[1:0];
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_both_held;
      cpu_core_reset_o && bus_reset_o;
   endsequence

   property p_sup_release;
      $rose(supervisor_reset_n_o) |-> $past(sup_ok) && $past(sup_cnt_q) == SUP_LAST;
   endproperty
   a_sup_release : assert property (p_sup_release) else $error("supervisor released early");

   property p_sup_drop;
      !supply_good_i |=> !supervisor_reset_n_o;
   endproperty
   a_sup_drop : assert property (p_sup_drop) else $error("supervisor kept high on supply loss");

   property p_manual;
      !manual_reset_in_n_o |=> !supervisor_reset_n_o;
   endproperty
   a_manual : assert property (p_manual) else $error("manual input did not force reset");

   property p_pulse;
      $fell(supervisor_reset_n_o) |-> !supervisor_reset_n_o [*8];
   endproperty
   a_pulse : assert property (p_pulse) else $error("supervisor pulse too short");

   property p_local;
      1'b1 |=> manual_reset_in_n_o == $past(config_done_i & push_button_n_i);
   endproperty
   a_local : assert property (p_local) else $error("local reset not the AND");

   property p_board;
      1'b1 |=> board_main_reset_n_o ==
               $past(config_done_i & push_button_n_i & interface_board_reset_n_i);
   endproperty
   a_board : assert property (p_board) else $error("board reset not the AND");

   property p_fanout;
      board_main_reset_n_o == board_reset_pwr_n_o && board_main_reset_n_o == board_reset_dp_n_o;
   endproperty
   a_fanout : assert property (p_fanout) else $error("board reset copies differ");

   property p_board_hold;
      !board_main_reset_n_o |=> s_both_held;
   endproperty
   a_board_hold : assert property (p_board_hold) else $error("board reset did not hold cpu");

   property p_lock_hold;
      !lock_status_net_o |=> s_both_held;
   endproperty
   a_lock_hold : assert property (p_lock_hold) else $error("no lock but cpu released");

   property p_debug;
      debug_system_reset_request_i |=> s_both_held;
   endproperty
   a_debug : assert property (p_debug) else $error("debug request ignored");

   // Checked from the core side: a hold source may legally hit the bus
   // one cycle after its release, but the core may never leave first
   property p_order;
      $fell(cpu_core_reset_o) |-> $past(!bus_reset_o) && $past(!bus_reset_o, 2);
   endproperty
   a_order : assert property (p_order) else $error("core released with bus");

   property p_release_tick;
      $fell(bus_reset_o) |-> $past(sys_tick) && $past(lock_status_net_o)
                          && $past(board_main_reset_n_o);
   endproperty
   a_release_tick : assert property (p_release_tick) else $error("release off system clock");

   property p_apb_ready;
      pready_o |=> !pready_o;
   endproperty
   a_apb_ready : assert property (p_apb_ready) else $error("ready held longer than one cycle");

endmodule : brc_top

// File: verif/brc_board_model.sv
`timescale 1ns/1ns
module brc_board_model (
   // Clock
   input  wire logic ref_clk_i,
   // Board levels seen by the sequencer
   output logic      supply_good_o,
   output logic      config_done_o,
   output logic      push_button_n_o,
   output logic      interface_board_reset_n_o
);
   // Supply off and unconfigured; button and interface line idle high
   initial begin
      supply_good_o             = 1'b0;
      config_done_o             = 1'b0;
      push_button_n_o           = 1'b1;
      interface_board_reset_n_o = 1'b1;
   end

   // All four levels change together, just after an edge
   task automatic drive_all(input logic s, input logic c, input logic b, input logic u);
      @(posedge ref_clk_i);
      supply_good_o             <= s;
      config_done_o             <= c;
      push_button_n_o           <= b;
      interface_board_reset_n_o <= u;
   endtask : drive_all

   // Interface board pulls its line low, then high again
   task automatic ui_pulse(input int n);
      @(posedge ref_clk_i);
      interface_board_reset_n_o <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
      interface_board_reset_n_o <= 1'b1;
   endtask : ui_pulse

   // Operator press after configuration; bounce is not modelled
   task automatic press(input int n);
      @(posedge ref_clk_i);
      push_button_n_o <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
      push_button_n_o <= 1'b1;
   endtask : press
endmodule : brc_board_model

// File: verif/brc_top_bench.sv
`timescale 1ns/1ns
module brc_top_bench;
   logic        ref_clk, rst, psel, penable, pwrite, dbg;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, c0;
   logic [3:0]  pstrb;
   logic        pready, pslverr, sup_good, cfg, btn_n, ui_n, err;
   logic        man_n, sup_n, brd_n, pwr_n, dp_n, cpu_rst, bus_rst, ck0, ck90, ckdv, lock;
   logic [15:0] h0, h90, hdv;
   logic        fb_bad, fb;

   // Feedback follows the in-phase clock unless a scenario breaks it
   assign fb = ck0 ^ fb_bad;
   int          error_cnt, samples_checked, cycles, n;

   // Reference clock, 100 ns period
   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   brc_top #(.LOCK_COUNT(2), .GAP_TICKS(1)) u_dut (
      .ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .supply_good_i(sup_good), .config_done_i(cfg), .push_button_n_i(btn_n),
      .interface_board_reset_n_i(ui_n), .debug_system_reset_request_i(dbg),
      .feedback_clock_i(fb), .manual_reset_in_n_o(man_n), .supervisor_reset_n_o(sup_n),
      .board_main_reset_n_o(brd_n), .board_reset_pwr_n_o(pwr_n), .board_reset_dp_n_o(dp_n),
      .cpu_core_reset_o(cpu_rst), .bus_reset_o(bus_rst), .clk_phase_zero_o(ck0),
      .clk_phase_quarter_o(ck90), .divided_clock_o(ckdv), .lock_status_net_o(lock));

   brc_board_model u_board (
      .ref_clk_i(ref_clk), .supply_good_o(sup_good), .config_done_o(cfg),
      .push_button_n_o(btn_n), .interface_board_reset_n_o(ui_n));

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_word

   // Wait k settled points (falling edges)
   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : cyc

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // No wait-state count is assumed; only the hang guard ends a lost answer
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      chk_bit(pready, 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   // Main sequence
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0000_0000; pstrb = 4'hF; dbg = 1'b0; fb_bad = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(1);
      chk_bit(sup_n, 1'b0); chk_bit(brd_n, 1'b0); chk_bit(cpu_rst, 1'b1);
      u_board.drive_all(1'b0, 1'b1, 1'b1, 1'b1);
      cyc(20);
      chk_bit(sup_n, 1'b0); chk_bit(cpu_rst, 1'b1);
      // Every combination of configuration, button and interface line
      for (int i = 0; i < 8; i++) begin
         u_board.drive_all(1'b1, i[2], i[1], i[0]);
         cyc(3);
         chk_bit(man_n, i[2] & i[1]);
         chk_bit(brd_n, &i[2:0]);
         chk_bit(pwr_n, &i[2:0]);
         chk_bit(dp_n, &i[2:0]);
         if (i < 7) chk_bit(bus_rst, 1'b1);
      end
      u_board.drive_all(1'b1, 1'b0, 1'b1, 1'b1);
      cyc(3);
      chk_bit(sup_n, 1'b0);
      u_board.drive_all(1'b1, 1'b1, 1'b1, 1'b1);
      n = 0;
      while (sup_n !== 1'b1 && n < 50) begin
         cyc(1);
         n++;
      end
      chk_bit(n >= 10 && n <= 12, 1'b1);
      n = 0;
      while (bus_rst !== 1'b0 && n < 300) begin
         cyc(1);
         n++;
      end
      chk_bit(lock, 1'b1); chk_bit(cpu_rst, 1'b1);
      n = 0;
      while (cpu_rst !== 1'b0 && n < 50) begin
         cyc(1);
         n++;
      end
      chk_bit(n >= 7 && n <= 9, 1'b1);
      // Clock shapes over sixteen reference cycles
      for (int i = 0; i < 16; i++) begin
         cyc(1);
         h0[i] = ck0; h90[i] = ck90; hdv[i] = ckdv;
      end
      for (int i = 4; i < 16; i++) begin
         chk_bit(h0[i], ~h0[i-2]);
         chk_bit(h90[i], h0[i-1]);
         chk_bit(hdv[i], ~hdv[i-4]);
      end
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk_word(rd, 32'h0000_041F);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk_bit(err, 1'b1); chk_word(rd, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0002);
      cyc(2);
      chk_bit(cpu_rst, 1'b1); chk_bit(bus_rst, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0001);
      cyc(2);
      chk_bit(bus_rst, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      c0 = rd;
      u_board.ui_pulse(3);
      cyc(40);
      u_board.press(3);
      cyc(40);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk_word(rd, c0 + 32'h0000_0002);
      chk_bit(cpu_rst, 1'b0);
      dbg <= 1'b1;
      cyc(2);
      chk_bit(cpu_rst, 1'b1); chk_bit(bus_rst, 1'b1);
      @(posedge ref_clk);
      dbg <= 1'b0;
      // Broken feedback must drop lock and hold the processor
      @(posedge ref_clk);
      fb_bad <= 1'b1;
      cyc(3);
      chk_bit(lock, 1'b0); chk_bit(cpu_rst, 1'b1); chk_bit(bus_rst, 1'b1);
      @(posedge ref_clk);
      fb_bad <= 1'b0;
      cyc(4);
      chk_bit(lock, 1'b1);
      u_board.drive_all(1'b0, 1'b1, 1'b1, 1'b1);
      cyc(2);
      chk_bit(sup_n, 1'b0);
      conclude();
   end
endmodule : brc_top_bench
